// [hw/msc_port.sv]
// Serial command port: pin sampling, command decode, register store
`timescale 1ns/1ns
`include "msc_defines.svh"
module msc_port (
  input wire logic clk_sys,
  input wire logic rst,
  input msc_pkg::msc_pins_t pins,
  output logic dout,
  output logic dout_oe_n,
  input msc_pkg::msc_result_t result_in,
  input wire logic result_valid,
  output logic result_ready,
  input wire logic [23:0] alarm_status,
  output logic conv_start,
  output logic [3:0] conv_chan,
  output logic clear_chan,
  output logic clear_all,
  output logic [3:0] clear_addr,
  output logic shutdown,
  output logic [15:0] chan_enable,
  output logic [15:0] input_cfg,
  output logic [7:0] setup_reg
);
  import msc_pkg::*;

  msc_state_t state;
  logic [2:0] pin_raw;
  logic [2:0] pin_f;
  logic cs_f;
  logic sclk_f;
  logic din_f;
  logic sclk_d;
  logic rise;
  logic fall;
  logic [2:0] bit_cnt;
  logic [7:0] sh_in;
  logic [7:0] cmd_next;
  logic [3:0] op;
  logic [3:0] addr;
  logic [4:0] byte_idx;
  logic cmd_done;
  logic wr_stb;
  logic addr_ok;
  logic reset_cmd;
  logic conv_pend;
  logic scan_mode;
  logic [2:0] tbit;
  logic [4:0] tx_idx;
  logic [7:0] tx_sh;
  logic [7:0] rd_byte;
  logic rd_msb;
  logic [11:0] cur [0:`MSC_NCHAN-1];
  logic [39:0] chcfg [0:`MSC_NCHAN-1];
  logic [39:0] glob;
  msc_result_t fifo_out;
  logic fifo_valid;
  logic drain;

  // Three-stage pin sampling; a level counts once stages two and three agree
  assign pin_raw = {pins.cs_n, pins.sclk, pins.din};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      logic [2:0] stg;
      logic flt;
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          stg <= {3{gi == 2}}; // Idle levels, so no false select after reset
          flt <= (gi == 2);
        end else begin
          stg <= {stg[1:0], pin_raw[gi]};
          if (stg[1] == stg[2]) begin
            flt <= stg[2];
          end
        end
      end
      assign pin_f[gi] = flt;
    end
  endgenerate
  assign cs_f = pin_f[2];
  assign sclk_f = pin_f[1];
  assign din_f = pin_f[0];

  // Edge finder; no idle level is assumed, so both clock modes work
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_f;
    end
  end
  assign rise = sclk_f && !sclk_d;
  assign fall = !sclk_f && sclk_d;

  // Decode helpers
  assign cmd_next = {sh_in[6:0], din_f};
  assign cmd_done = !cs_f && (state == ST_CMD) && rise && (bit_cnt == 3'h7);
  assign wr_stb = !cs_f && (state == ST_DATA) && rise && (bit_cnt == 3'h7);
  assign addr_ok = (addr <= `MSC_LAST_CHAN);
  assign reset_cmd = cmd_done && (cmd_next[7:4] == `MSC_OP_RESET);
  assign scan_mode = glob[`MSC_SCAN_BIT];
  assign chan_enable = glob[39:24];
  assign input_cfg = glob[23:8];
  assign setup_reg = glob[7:0];

  // Reserved opcode test
  function automatic logic is_rsv(input logic [3:0] o);
    is_rsv = (o == `MSC_OP_RSV6) || (o == `MSC_OP_RSVE) || (o == `MSC_OP_RSVF);
  endfunction : is_rsv

  // Byte i of a five-byte group, first byte highest
  function automatic logic [7:0] byte_of(input logic [39:0] w, input logic [4:0] i);
    case (i)
      5'h00: byte_of = w[39:32];
      5'h01: byte_of = w[31:24];
      5'h02: byte_of = w[23:16];
      5'h03: byte_of = w[15:8];
      5'h04: byte_of = w[7:0];
      default: byte_of = 8'h00;
    endcase
  endfunction : byte_of

  // Replace byte i of a five-byte group
  function automatic logic [39:0] put5(input logic [39:0] w, input logic [4:0] i,
                                       input logic [7:0] b);
    logic [39:0] r;
    r = w;
    case (i)
      5'h00: r[39:32] = b;
      5'h01: r[31:24] = b;
      5'h02: r[23:16] = b;
      5'h03: r[15:8] = b;
      5'h04: r[7:0] = b;
      default: r = w;
    endcase
    put5 = r;
  endfunction : put5

  // Result coding: unsigned clamps negatives, signed saturates
  function automatic logic [11:0] fmt_code(input msc_result_t r);
    logic signed [12:0] v;
    v = r.raw;
    case (r.mode)
      MODE_SE, MODE_UNI: fmt_code = (v < 13'sh0000) ? 12'h000 : v[11:0];
      default: begin
        if (v > 13'sh07FF) begin
          fmt_code = 12'h7FF;
        end else if (v < 13'sh1800) begin
          fmt_code = 12'h800;
        end else begin
          fmt_code = v[11:0];
        end
      end
    endcase
  endfunction : fmt_code

  // Command and data receive engine
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      sh_in <= 8'h00;
      op <= 4'h0;
      addr <= 4'h0;
      byte_idx <= 5'h00;
    end else if (cs_f) begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          state <= ST_CMD;
          bit_cnt <= 3'h0;
          byte_idx <= 5'h00;
        end
        ST_CMD: begin
          if (rise) begin
            sh_in <= cmd_next;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
              op <= cmd_next[7:4];
              addr <= cmd_next[3:0];
              state <= is_rsv(cmd_next[7:4]) ? ST_SKIP : ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (rise) begin
            sh_in <= cmd_next;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7 && byte_idx != 5'h1F) begin
              byte_idx <= byte_idx + 5'h01;
            end
          end
        end
        ST_SKIP: state <= ST_SKIP;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Manual conversion starts when select returns high
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      conv_pend <= 1'b0;
      conv_start <= 1'b0;
      conv_chan <= 4'h0;
    end else begin
      conv_start <= 1'b0;
      if (cmd_done) begin
        conv_pend <= (cmd_next[7:4] == `MSC_OP_CONV) && !scan_mode
                     && (cmd_next[3:0] <= `MSC_LAST_CHAN);
        conv_chan <= cmd_next[3:0];
      end else if (cs_f && conv_pend) begin
        conv_pend <= 1'b0;
        conv_start <= 1'b1;
      end
    end
  end

  // Alarm clear pulses and shutdown flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clear_chan <= 1'b0;
      clear_all <= 1'b0;
      clear_addr <= 4'h0;
      shutdown <= 1'b1;
    end else begin
      clear_chan <= 1'b0;
      clear_all <= 1'b0;
      if (cmd_done && cmd_next[7:4] == `MSC_OP_CLR1 && cmd_next[3:0] <= `MSC_LAST_CHAN) begin
        clear_chan <= 1'b1;
        clear_addr <= cmd_next[3:0];
      end
      if (cmd_done && cmd_next[7:4] == `MSC_OP_CLRALL) begin
        clear_all <= 1'b1;
      end
      if (wr_stb && op == `MSC_OP_WCFG1 && addr_ok && byte_idx == 5'h04) begin
        clear_chan <= 1'b1;
        clear_addr <= addr;
      end
      if (reset_cmd) begin
        shutdown <= 1'b1;
      end else if (wr_stb && op == `MSC_OP_WGLOB && byte_idx == 5'h04) begin
        shutdown <= 1'b0;
      end
    end
  end

  // Register store: serial writes, reset command, converter results
  always_ff @(posedge clk_sys) begin
    if (rst || reset_cmd) begin
      for (int i = 0; i < `MSC_NCHAN; i++) begin
        cur[i] <= `MSC_CUR_RST;
        chcfg[i] <= `MSC_CHCFG_RST;
      end
      glob <= `MSC_GLOB_RST;
    end else if (wr_stb) begin
      case (op)
        `MSC_OP_WCUR1: begin
          if (addr_ok && byte_idx == 5'h00) begin
            cur[addr][11:4] <= cmd_next;
          end else if (addr_ok && byte_idx == 5'h01) begin
            cur[addr][3:0] <= cmd_next[7:4];
          end
        end
        `MSC_OP_WCURALL: begin
          if (byte_idx < `MSC_LEN_CURALL && !byte_idx[0]) begin
            cur[byte_idx[4:1]][11:4] <= cmd_next;
          end else if (byte_idx < `MSC_LEN_CURALL) begin
            cur[byte_idx[4:1]][3:0] <= cmd_next[7:4];
          end
        end
        `MSC_OP_WCFG1: begin
          if (addr_ok && byte_idx < `MSC_LEN_CFG) begin
            chcfg[addr] <= put5(chcfg[addr], byte_idx, cmd_next);
          end
        end
        `MSC_OP_WGLOB: begin
          if (byte_idx < `MSC_LEN_GLOB) begin
            glob <= put5(glob, byte_idx, cmd_next);
          end
        end
        default: glob <= glob;
      endcase
    end else if (drain && fifo_out.chan <= `MSC_LAST_CHAN) begin
      cur[fifo_out.chan] <= fmt_code(fifo_out);
    end
  end

  // Results wait in the buffer while a transfer is under way
  assign drain = fifo_valid && cs_f;
  msc_fifo2 #(
    .DEPTH(2)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_data(result_in),
    .in_valid(result_valid),
    .in_ready(result_ready),
    .out_data(fifo_out),
    .out_valid(fifo_valid),
    .out_ready(cs_f)
  );

  // Byte to send for the current opcode and byte count
  always_comb begin
    rd_byte = 8'h00;
    case (op)
      `MSC_OP_ALARM: begin
        if (tx_idx < `MSC_LEN_ALARM) begin
          rd_byte = byte_of({alarm_status, 16'h0000}, tx_idx);
        end
      end
      `MSC_OP_CUR1: begin
        if (addr_ok && tx_idx < `MSC_LEN_CUR1) begin
          rd_byte = tx_idx[0] ? {cur[addr][3:0], 4'h0} : cur[addr][11:4];
        end
      end
      `MSC_OP_CURALL: begin
        if (tx_idx < `MSC_LEN_CURALL) begin
          rd_byte = tx_idx[0] ? {cur[tx_idx[4:1]][3:0], 4'h0}
                              : cur[tx_idx[4:1]][11:4];
        end
      end
      `MSC_OP_CFG1: begin
        if (addr_ok && tx_idx < `MSC_LEN_CFG) begin
          rd_byte = byte_of(chcfg[addr], tx_idx);
        end
      end
      `MSC_OP_GLOB: begin
        if (tx_idx < `MSC_LEN_GLOB) begin
          rd_byte = byte_of(glob, tx_idx);
        end
      end
      default: rd_byte = 8'h00;
    endcase
  end
  assign rd_msb = rd_byte[7];

  // Transmit engine: output changes only on falling edges after the command
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dout <= 1'b0;
      dout_oe_n <= 1'b1;
      tbit <= 3'h0;
      tx_idx <= 5'h00;
      tx_sh <= 8'h00;
    end else begin
      dout_oe_n <= cs_f;
      if (cs_f || state != ST_DATA) begin
        dout <= 1'b0;
        tbit <= 3'h0;
        tx_idx <= 5'h00;
      end else if (fall) begin
        if (tbit == 3'h0) begin
          dout <= rd_byte[7];
          tx_sh <= {rd_byte[6:0], 1'b0};
        end else begin
          dout <= tx_sh[7];
          tx_sh <= {tx_sh[6:0], 1'b0};
        end
        tbit <= tbit + 3'h1;
        if (tbit == 3'h7 && tx_idx != 5'h1F) begin
          tx_idx <= tx_idx + 5'h01;
        end
      end
    end
  end

  // Checks on the engine
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_idle_on_cs: assert property (cs_f |=> state == ST_IDLE)
    else $error("port not idle after select high");
  a_oe_follows_cs: assert property (cs_f ##1 cs_f |-> dout_oe_n)
    else $error("output driven while select high");
  a_cmd_fields: assert property (cmd_done |=> {op, addr} == $past(cmd_next))
    else $error("command fields not captured");
  a_first_bit: assert property ((state == ST_DATA && fall && tbit == 3'h0 && !cs_f)
    |=> dout == $past(rd_msb))
    else $error("first output bit wrong");
  a_quiet_in_cmd: assert property ((state == ST_CMD) ##1 (state == ST_CMD) |-> !dout)
    else $error("output moved before command end");
  a_conv_blocked: assert property (conv_start |-> !scan_mode && $past(cs_f))
    else $error("conversion started in scan mode");
  a_clear_all_pulse: assert property ((cmd_done && cmd_next[7:4] == `MSC_OP_CLRALL)
    |=> clear_all ##1 !clear_all)
    else $error("clear all pulse wrong");
  a_pad_zero: assert property ((op == `MSC_OP_CUR1 || op == `MSC_OP_CURALL) && tx_idx[0]
    |-> rd_byte[3:0] == 4'h0)
    else $error("result pad bits not zero");
  a_unipolar_clamp: assert property ((drain && (fifo_out.mode == MODE_UNI
    || fifo_out.mode == MODE_SE) && fifo_out.raw[12] && fifo_out.chan == 4'h2)
    |=> cur[2] == 12'h000)
    else $error("negative unipolar result not zero");
  a_reset_shutdown: assert property (reset_cmd |=> shutdown && glob == `MSC_GLOB_RST)
    else $error("reset command did not restore");
  a_reserved_quiet: assert property ((state == ST_SKIP) ##1 (state == ST_SKIP)
    |-> !dout && !clear_chan && !clear_all && !conv_pend)
    else $error("reserved opcode had an effect");

endmodule : msc_port

// [hw/msc_defines.svh]
// Constants of the monitor serial command port
`ifndef MSC_DEFINES_SVH
`define MSC_DEFINES_SVH

// Channel count and highest valid address
`define MSC_NCHAN 10
`define MSC_LAST_CHAN 4'h9

// Opcodes in the upper command nibble
`define MSC_OP_CONV 4'h0
`define MSC_OP_ALARM 4'h1
`define MSC_OP_CUR1 4'h2
`define MSC_OP_CURALL 4'h3
`define MSC_OP_CFG1 4'h4
`define MSC_OP_GLOB 4'h5
`define MSC_OP_RSV6 4'h6
`define MSC_OP_RESET 4'h7
`define MSC_OP_CLR1 4'h8
`define MSC_OP_CLRALL 4'h9
`define MSC_OP_WCUR1 4'hA
`define MSC_OP_WCURALL 4'hB
`define MSC_OP_WCFG1 4'hC
`define MSC_OP_WGLOB 4'hD
`define MSC_OP_RSVE 4'hE
`define MSC_OP_RSVF 4'hF

// Data byte counts per command
`define MSC_LEN_ALARM 5'h03
`define MSC_LEN_CUR1 5'h02
`define MSC_LEN_CURALL 5'h14
`define MSC_LEN_CFG 5'h05
`define MSC_LEN_GLOB 5'h05

// Field positions and power-on values
`define MSC_SCAN_BIT 0
`define MSC_CUR_RST 12'h000
`define MSC_CHCFG_RST 40'h0000000000
`define MSC_GLOB_RST 40'h0000000000

// Serial clock limit and its cycle count at the system rate
`define MSC_SYS_HZ 10000000
`define MSC_SCLK_MAX_HZ 10000000
`define MSC_SCLK_MIN_PER_CYC ((`MSC_SYS_HZ + `MSC_SCLK_MAX_HZ - 1) / `MSC_SCLK_MAX_HZ)

`endif

// [hw/msc_pkg.sv]
// Types of the monitor serial command port
package msc_pkg;

  // Serial engine states
  typedef enum {ST_IDLE, ST_CMD, ST_DATA, ST_SKIP} msc_state_t;

  // Coding of a conversion result
  typedef enum logic [1:0] {MODE_SE, MODE_UNI, MODE_BIP, MODE_TEMP} msc_mode_t;

  // Serial pins from the host
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } msc_pins_t;

  // Raw conversion result from the converter
  typedef struct packed {
    logic [3:0] chan;
    msc_mode_t mode;
    logic signed [12:0] raw;
  } msc_result_t;

endpackage : msc_pkg

// [hw/msc_fifo2.sv]
// Two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ns
module msc_fifo2 #(
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input msc_pkg::msc_result_t in_data,
  input wire logic in_valid,
  output logic in_ready,
  output msc_pkg::msc_result_t out_data,
  output logic out_valid,
  input wire logic out_ready
);
  import msc_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  msc_result_t mem [0:DEPTH-1];
  logic [PW-1:0] wp;
  logic [PW-1:0] rp;
  logic [PW:0] cnt;
  logic [PW:0] next_cnt;
  logic push;
  logic pop;

  // Handshakes and read port
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt != '0);
  assign out_data = mem[rp];

  // Fill level after this cycle
  always_comb begin
    next_cnt = cnt;
    if (push && !pop) begin
      next_cnt = cnt + 1'b1;
    end else if (pop && !push) begin
      next_cnt = cnt - 1'b1;
    end
  end

  // Level, pointers and registered ready
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt <= '0;
      wp <= '0;
      rp <= '0;
      in_ready <= 1'b1;
    end else begin
      cnt <= next_cnt;
      in_ready <= (next_cnt != (PW+1)'(DEPTH));
      if (push) begin
        wp <= (wp == PW'(DEPTH - 1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == PW'(DEPTH - 1)) ? '0 : rp + 1'b1;
      end
    end
  end

  // Storage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

endmodule : msc_fifo2

// [tb/msc_host.sv]
// Host serial master model that drives the command port pins
`timescale 1ns/1ns
module msc_host (
  input wire logic clk_sys,
  output msc_pkg::msc_pins_t pins,
  input wire logic dout,
  input wire logic dout_oe_n
);
  import msc_pkg::*;
  logic line;
  logic mode3;

  // Serial output as the host sees it, floating when not driven
  assign line = dout_oe_n ? 1'bz : dout;

  initial begin
    pins = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
    mode3 = 1'b0;
  end

  // Clock parked at its idle level, then select falls before any edge
  task automatic open_frame(input logic m3);
    @(posedge clk_sys) #1;
    mode3 = m3;
    pins.sclk = m3;
    #800;
    pins.cs_n = 1'b0;
    #800;
  endtask : open_frame

  // Shift up to eight bits MSB first, sampling the reply late in the high phase
  task automatic shift(input int nbits, input logic [7:0] wr, output logic [7:0] rd);
    rd = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      pins.sclk = 1'b0;
      pins.din = wr[i];
      #400;
      pins.sclk = 1'b1;
      #400;
      rd[i] = line;
    end
  endtask : shift

  // Return clock to idle, raise select, scramble the released data line
  task automatic close_frame();
    if (!mode3) begin
      pins.sclk = 1'b0;
      #400;
    end
    pins.cs_n = 1'b1;
    pins.din = ~pins.din;
    #1200;
  endtask : close_frame
endmodule : msc_host

// [tb/monitor_serial_command_port_bench.sv]
// Self-checking bench of the serial command port
`timescale 1ns/1ns
module monitor_serial_command_port_bench;
  import msc_pkg::*;
  logic clk_sys, rst, dout, dout_oe_n, result_valid, result_ready;
  logic conv_start, clear_chan, clear_all, shutdown;
  logic [3:0] conv_chan, clear_addr, clr_at;
  logic [15:0] chan_enable, input_cfg;
  logic [7:0] setup_reg;
  logic [23:0] alarm_status;
  msc_pins_t pins;
  msc_result_t result_in;
  logic [7:0] wbuf [20];
  logic [7:0] rbuf [20];
  logic [11:0] ec [10];
  int miscompares, cmp_count, n_conv, n_clr, n_all;

  msc_port u_dut (.clk_sys(clk_sys), .rst(rst), .pins(pins), .dout(dout),
    .dout_oe_n(dout_oe_n), .result_in(result_in), .result_valid(result_valid),
    .result_ready(result_ready), .alarm_status(alarm_status), .conv_start(conv_start),
    .conv_chan(conv_chan), .clear_chan(clear_chan), .clear_all(clear_all),
    .clear_addr(clear_addr), .shutdown(shutdown), .chan_enable(chan_enable),
    .input_cfg(input_cfg), .setup_reg(setup_reg));
  msc_host u_host (.clk_sys(clk_sys), .pins(pins), .dout(dout), .dout_oe_n(dout_oe_n));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Pulse counters for the command side effects
  always @(posedge clk_sys) begin
    if (conv_start === 1'b1) n_conv++;
    if (clear_chan === 1'b1) begin
      n_clr++;
      clr_at = clear_addr;
    end
    if (clear_all === 1'b1) n_all++;
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One whole command frame with n data bytes
  task automatic xfer(input logic m3, input logic [7:0] cmd, input int n);
    logic [7:0] r;
    u_host.open_frame(m3);
    u_host.shift(8, cmd, r);
    for (int k = 0; k < n; k++) u_host.shift(8, wbuf[k], rbuf[k]);
    u_host.close_frame();
    chk(dout_oe_n, 1'b1);
  endtask : xfer

  task automatic push(input msc_result_t w);
    @(posedge clk_sys) #1;
    result_in = w;
    result_valid = 1'b1;
    do @(posedge clk_sys); while (result_ready !== 1'b1);
    #1 result_valid = 1'b0;
  endtask : push

  task automatic rd_all();
    xfer(1'b0, 8'h3D, 20);
    for (int c = 0; c < 10; c++) begin
      chk(rbuf[2*c], ec[c][11:4]);
      chk(rbuf[2*c+1], {ec[c][3:0], 4'h0});
    end
  endtask : rd_all

  task automatic t_glob();
    logic [39:0] g;
    g = 40'h123456789A;
    for (int k = 0; k < 5; k++) wbuf[k] = g[39-8*k -: 8];
    xfer(1'b1, 8'hD7, 5);
    chk({chan_enable, input_cfg, setup_reg}, g);
    chk(shutdown, 1'b0);
    xfer(1'b0, 8'h5C, 5);
    for (int k = 0; k < 5; k++) chk(rbuf[k], g[39-8*k -: 8]);
  endtask : t_glob

  task automatic t_conv();
    int n0;
    n0 = n_conv;
    xfer(1'b0, 8'h05, 0);
    chk(n_conv - n0, 1);
    chk(conv_chan, 4'h5);
    wbuf[4] = 8'h01;
    xfer(1'b1, 8'hD0, 5);
    xfer(1'b1, 8'h06, 0);
    chk(n_conv - n0, 1);
  endtask : t_conv

  task automatic t_wall();
    for (int c = 0; c < 10; c++) begin
      ec[c] = {8'h30 + 8'(8 * c), 4'(c)};
      wbuf[2*c] = ec[c][11:4];
      wbuf[2*c+1] = {ec[c][3:0], 4'hF};
    end
    xfer(1'b1, 8'hB6, 20);
    rd_all();
  endtask : t_wall

  // Results arrive mid-frame, the buffer refuses, then drains after select rises
  task automatic t_buf();
    logic [7:0] r;
    u_host.open_frame(1'b0);
    u_host.shift(8, 8'h6F, r);
    push('{4'h2, MODE_SE, 13'h1FFB});
    push('{4'h3, MODE_UNI, 13'h0ABC});
    fork
      push('{4'h4, MODE_BIP, 13'h0BB8});
      begin
        repeat (6) @(posedge clk_sys);
        #1;
        chk(result_ready, 1'b0);
        u_host.shift(8, 8'hFF, r);
        chk(r, 8'h00);
        u_host.close_frame();
      end
    join
    push('{4'h5, MODE_TEMP, 13'h1448});
    ec[2] = 12'h000;
    ec[3] = 12'hABC;
    ec[4] = 12'h7FF;
    ec[5] = 12'h800;
    rd_all();
  endtask : t_buf

  task automatic t_wcur();
    logic [7:0] r;
    wbuf[0] = 8'hAB;
    wbuf[1] = 8'hCF;
    xfer(1'b1, 8'hA7, 2);
    xfer(1'b0, 8'h27, 2);
    chk({rbuf[0], rbuf[1]}, 16'hABC0);
    u_host.open_frame(1'b0);
    u_host.shift(4, 8'h70, r);
    u_host.close_frame();
    chk(shutdown, 1'b0);
    xfer(1'b1, 8'h27, 2);
    chk({rbuf[0], rbuf[1]}, 16'hABC0);
  endtask : t_wcur

  task automatic t_cfg();
    int n0;
    n0 = n_clr;
    for (int k = 0; k < 5; k++) wbuf[k] = 8'hC1 + 8'(k);
    xfer(1'b0, 8'hC1, 5);
    chk(n_clr - n0, 1);
    chk(clr_at, 4'h1);
    xfer(1'b1, 8'h41, 5);
    for (int k = 0; k < 5; k++) chk(rbuf[k], 8'hC1 + 8'(k));
    xfer(1'b0, 8'h42, 5);
    for (int k = 0; k < 5; k++) chk(rbuf[k], 8'h00);
  endtask : t_cfg

  task automatic t_clear();
    int n0, n1;
    n0 = n_clr;
    n1 = n_all;
    xfer(1'b1, 8'h83, 0);
    chk(n_clr - n0, 1);
    chk(clr_at, 4'h3);
    xfer(1'b0, 8'h9F, 0);
    chk(n_all - n1, 1);
    xfer(1'b1, 8'h1E, 3);
    for (int k = 0; k < 3; k++) chk(rbuf[k], alarm_status[23-8*k -: 8]);
    xfer(1'b1, 8'h7A, 0);
    chk(shutdown, 1'b1);
    chk({chan_enable, input_cfg, setup_reg}, 40'h0);
  endtask : t_clear

  task automatic wrap_up();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  // Hang guard, about three and a half times the expected run
  initial begin
    #3000000;
    miscompares++;
    $display("Error %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    result_in = '0;
    result_valid = 1'b0;
    alarm_status = 24'hA53C96;
    miscompares = 0;
    cmp_count = 0;
    n_conv = 0;
    n_clr = 0;
    n_all = 0;
    clr_at = 4'h0;
    repeat (3) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(shutdown, 1'b1);
    chk(dout_oe_n, 1'b1);
    t_glob();
    t_conv();
    t_wall();
    t_buf();
    t_wcur();
    t_cfg();
    t_clear();
    wrap_up();
  end
endmodule : monitor_serial_command_port_bench
